/* File: design/rgr_pkg.sv */
package rgr_pkg;
   localparam logic [6:0] ADDR_EXP_SYNC = 7'h29;
   localparam logic [6:0] ADDR_GUARD_CNT = 7'h76;
   localparam logic [6:0] ADDR_GUARD_LEFT = 7'h77;
   localparam int BIT_INTE_SYNC = 2;
   localparam int BIT_EXP_DUAL = 1;
   localparam logic [7:0] RST_EXP_SYNC = 8'h00;
   localparam logic [7:0] RST_GUARD_CNT = 8'h00;
   localparam logic [7:0] REG_ZERO = 8'h00;
   localparam int DATA_W = 10;
   localparam int SMP_W = DATA_W + 5;
   localparam int SMP_CLK = DATA_W + 4;
   localparam int SMP_XFER = DATA_W + 3;
   localparam int SMP_FV = DATA_W + 2;
   localparam int SMP_LV = DATA_W + 1;
   localparam int SMP_PV = DATA_W;
endpackage

/* File: design/rgr_guard_row_inserter.sv */
`timescale 1ns/1ps
`default_nettype none
module rgr_guard_row_inserter
   import rgr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   output logic [7:0] reg_rdata,
   input wire logic lnk_clk,
   input wire logic xfer_pulse,
   input wire logic seq_frame_valid,
   input wire logic seq_line_valid,
   input wire logic seq_pixel_valid,
   input wire logic [DATA_W-1:0] seq_data,
   output logic frame_valid,
   output logic line_valid,
   output logic pixel_valid,
   output logic [DATA_W-1:0] pix_data
);
   logic rst_s1_r;
   logic rst_n;
   logic [SMP_W-1:0] smp1_r;
   logic [SMP_W-1:0] smp2_r;
   logic lclk_d_r;
   logic xfer_d_r;
   logic [7:0] exp_sync_r;
   logic [7:0] exp_sync_nxt;
   logic [7:0] guard_cnt_r;
   logic [7:0] guard_cnt_nxt;
   logic [7:0] guard_left_r;
   logic [7:0] guard_left_nxt;
   logic row_sup_r;
   logic row_sup_nxt;
   logic lv_prev_r;
   logic lv_prev_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic fv_r;
   logic fv_nxt;
   logic lv_r;
   logic lv_nxt;
   logic pv_r;
   logic pv_nxt;
   logic [DATA_W-1:0] data_r;
   logic [DATA_W-1:0] data_nxt;
   logic lnk_rise;
   logic xfer_rise;
   logic insert_en;
   logic load;
   logic row_start;
   logic row_end;
   logic sup_eff;

   function automatic logic is_nonzero(input logic [7:0] value);
      return value != REG_ZERO;
   endfunction

   // Reset is released through two flip-flops.
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_s1_r <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_s1_r <= 1'b1;
         rst_n <= rst_s1_r;
      end
   end

   // All stream inputs and the link clock pass two flip-flops.
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         smp1_r <= '0;
         smp2_r <= '0;
         lclk_d_r <= 1'b0;
         xfer_d_r <= 1'b0;
      end
      else
      begin
         smp1_r <= {lnk_clk, xfer_pulse, seq_frame_valid, seq_line_valid, seq_pixel_valid,
                    seq_data};
         smp2_r <= smp1_r;
         lclk_d_r <= smp2_r[SMP_CLK];
         xfer_d_r <= smp2_r[SMP_XFER];
      end
   end

   assign lnk_rise = smp2_r[SMP_CLK] & ~lclk_d_r;
   assign xfer_rise = smp2_r[SMP_XFER] & ~xfer_d_r;
   assign insert_en = exp_sync_r[BIT_INTE_SYNC] & is_nonzero(guard_cnt_r);
   // Single exposure loads only when idle; dual exposure reloads at each pulse.
   assign load = xfer_rise & insert_en & (~is_nonzero(guard_left_r)
                 | exp_sync_r[BIT_EXP_DUAL]);
   assign row_start = lnk_rise & smp2_r[SMP_LV] & ~lv_prev_r;
   assign row_end = lnk_rise & ~smp2_r[SMP_LV] & lv_prev_r;
   assign sup_eff = row_start ? is_nonzero(guard_left_r) : row_sup_r;

   always_comb
   begin
      exp_sync_nxt = exp_sync_r;
      guard_cnt_nxt = guard_cnt_r;
      if (reg_wr && reg_addr == ADDR_EXP_SYNC)
         exp_sync_nxt = reg_wdata;
      if (reg_wr && reg_addr == ADDR_GUARD_CNT)
         guard_cnt_nxt = reg_wdata;
      case (reg_addr)
         ADDR_EXP_SYNC: rdata_nxt = exp_sync_r;
         ADDR_GUARD_CNT: rdata_nxt = guard_cnt_r;
         ADDR_GUARD_LEFT: rdata_nxt = guard_left_r;
         default: rdata_nxt = REG_ZERO;
      endcase
   end

   always_comb
   begin
      guard_left_nxt = guard_left_r;
      row_sup_nxt = row_sup_r;
      lv_prev_nxt = lv_prev_r;
      fv_nxt = fv_r;
      lv_nxt = lv_r;
      pv_nxt = pv_r;
      data_nxt = data_r;
      if (lnk_rise)
      begin
         lv_prev_nxt = smp2_r[SMP_LV];
         if (row_start)
            row_sup_nxt = is_nonzero(guard_left_r);
         if (row_end && row_sup_r)
         begin
            // One guard row ends with its line_valid period, whatever slots it held.
            guard_left_nxt = guard_left_r - 8'h01;
            row_sup_nxt = 1'b0;
         end
         fv_nxt = smp2_r[SMP_FV];
         lv_nxt = smp2_r[SMP_LV] & ~sup_eff;
         pv_nxt = smp2_r[SMP_PV] & ~sup_eff;
         data_nxt = smp2_r[DATA_W-1:0];
      end
      if (load)
         guard_left_nxt = guard_cnt_r;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         exp_sync_r <= RST_EXP_SYNC;
         guard_cnt_r <= RST_GUARD_CNT;
         rdata_r <= REG_ZERO;
         guard_left_r <= REG_ZERO;
         row_sup_r <= 1'b0;
         lv_prev_r <= 1'b0;
         fv_r <= 1'b0;
         lv_r <= 1'b0;
         pv_r <= 1'b0;
         data_r <= '0;
      end
      else
      begin
         exp_sync_r <= exp_sync_nxt;
         guard_cnt_r <= guard_cnt_nxt;
         rdata_r <= rdata_nxt;
         guard_left_r <= guard_left_nxt;
         row_sup_r <= row_sup_nxt;
         lv_prev_r <= lv_prev_nxt;
         fv_r <= fv_nxt;
         lv_r <= lv_nxt;
         pv_r <= pv_nxt;
         data_r <= data_nxt;
      end
   end

   assign reg_rdata = rdata_r;
   assign frame_valid = fv_r;
   assign line_valid = lv_r;
   assign pixel_valid = pv_r;
   assign pix_data = data_r;

   a_guard_row_blank: assert property (@(posedge sys_clk) disable iff (!rst_n)
      row_sup_r |-> !line_valid && !pixel_valid)
      else $error("Valid strobe seen during a guard row.");

   a_guard_load_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
      xfer_rise && insert_en && guard_left_r == REG_ZERO |=> guard_left_r == $past(guard_cnt_r))
      else $error("Guard rows not loaded at transfer pulse.");

   a_single_ignore: assert property (@(posedge sys_clk) disable iff (!rst_n)
      xfer_rise && !exp_sync_r[BIT_EXP_DUAL] && is_nonzero(guard_left_r) && !row_end
      |=> guard_left_r == $past(guard_left_r))
      else $error("Transfer pulse reloaded guard rows in single exposure.");

   a_reset_cleared: assert property (@(posedge sys_clk)
      $rose(rst_n) |-> guard_cnt_r == REG_ZERO && !exp_sync_r[BIT_INTE_SYNC])
      else $error("Guard settings not cleared by reset.");

   a_row_decrement: assert property (@(posedge sys_clk) disable iff (!rst_n)
      row_end && row_sup_r && !load |=> guard_left_r == $past(guard_left_r) - 8'h01)
      else $error("Guard count not reduced at row end.");

   a_whole_rows_only: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $changed(guard_left_r) |-> $past(load) || $past(row_end && row_sup_r))
      else $error("Guard count changed inside a row.");

   a_dual_reload: assert property (@(posedge sys_clk) disable iff (!rst_n)
      xfer_rise && insert_en && exp_sync_r[BIT_EXP_DUAL] ##1 1'b1
      |-> guard_left_r == $past(guard_cnt_r))
      else $error("Second transfer pulse did not reload guard rows.");

   a_frame_kept: assert property (@(posedge sys_clk) disable iff (!rst_n)
      lnk_rise && smp2_r[SMP_FV] && sup_eff |=> frame_valid ##1 !row_sup_r || frame_valid
      || !$past(smp2_r[SMP_FV]))
      else $error("frame_valid dropped in a guard row.");

   a_disabled_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !insert_en && guard_left_r == REG_ZERO |=> guard_left_r == REG_ZERO)
      else $error("Guard rows started while insertion disabled.");
endmodule
`default_nettype wire

/* File: dv/rgr_rx_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rgr_rx_model
(
   input wire logic sys_clk,
   input wire logic line_valid,
   output logic [7:0] rows
);
   logic lv_d;
   initial rows = 8'h00;
   initial lv_d = 1'b0;
   // Counts a row only where line_valid rises.
   always @(posedge sys_clk)
   begin
      lv_d <= line_valid;
      if (line_valid && !lv_d)
      begin
         rows <= rows + 8'h01;
      end
   end
endmodule
`default_nettype wire

/* File: dv/test_readout_guard_row_inserter.sv */
`timescale 1ns/1ps
`default_nettype none
module test_readout_guard_row_inserter;
   import rgr_pkg::*;
   logic sys_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, lnk_clk = 1'b0, xfer_pulse = 1'b0;
   logic [6:0] reg_addr = 7'h00;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, rows, base;
   logic sfv = 1'b0, slv = 1'b0, spv = 1'b0, frame_valid, line_valid, pixel_valid;
   logic [DATA_W-1:0] seq_data = '0, pix_data;
   int error_cnt = 0, comparisons = 0;
   rgr_guard_row_inserter uut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .lnk_clk(lnk_clk),
      .xfer_pulse(xfer_pulse), .seq_frame_valid(sfv), .seq_line_valid(slv),
      .seq_pixel_valid(spv), .seq_data(seq_data), .frame_valid(frame_valid),
      .line_valid(line_valid), .pixel_valid(pixel_valid), .pix_data(pix_data));
   rgr_rx_model rx (.sys_clk(sys_clk), .line_valid(line_valid), .rows(rows));
   initial forever #25 sys_clk = ~sys_clk;
   task chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task finish_test();
      if (error_cnt == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge sys_clk);
      reg_wr = 1'b0;
   endtask
   task rd(input logic [6:0] a, input logic [7:0] e);
      @(negedge sys_clk);
      reg_addr = a;
      repeat (2) @(negedge sys_clk);
      chk(reg_rdata, e);
   endtask
   task tick(input logic lv, input logic pv);
      @(negedge sys_clk);
      lnk_clk = 1'b0;
      slv = lv;
      spv = pv;
      seq_data = seq_data + 1'b1;
      repeat (4) @(negedge sys_clk);
      lnk_clk = 1'b1;
      repeat (3) @(negedge sys_clk);
   endtask
   task pulse();
      xfer_pulse = 1'b1;
      tick(1'b0, 1'b0);
      xfer_pulse = 1'b0;
      tick(1'b0, 1'b0);
   endtask
   // A row holds two pixel slots with a gap between them.
   task row(input logic g);
      tick(1'b1, 1'b1);
      chk({7'h00, line_valid}, {7'h00, ~g});
      chk({7'h00, pixel_valid}, {7'h00, ~g});
      chk(pix_data[7:0], seq_data[7:0]);
      tick(1'b1, 1'b0);
      chk({7'h00, pixel_valid}, 8'h00);
      tick(1'b1, 1'b1);
      chk({7'h00, frame_valid}, 8'h01);
      tick(1'b0, 1'b0);
   endtask
   initial
   begin
      #2000000;
      error_cnt++;
      finish_test();
   end
   initial
   begin
      repeat (3) @(negedge sys_clk);
      rst_b = 1'b1;
      repeat (4) @(negedge sys_clk);
      rd(ADDR_EXP_SYNC, 8'h00);
      rd(ADDR_GUARD_CNT, 8'h00);
      wr(ADDR_EXP_SYNC, 8'h04);
      wr(ADDR_GUARD_CNT, 8'h01);
      rd(ADDR_GUARD_CNT, 8'h01);
      wr(ADDR_GUARD_CNT, 8'h02);
      rd(ADDR_GUARD_CNT, 8'h02);
      rd(ADDR_EXP_SYNC, 8'h04);
      wr(7'h62, 8'h6A);
      wr(7'h63, 8'h6A);
      rd(7'h62, 8'h00);
      rd(7'h10, 8'h00);
      wr(ADDR_GUARD_LEFT, 8'h05);
      rd(ADDR_GUARD_LEFT, 8'h00);
      sfv = 1'b1;
      base = rows;
      pulse();
      rd(ADDR_GUARD_LEFT, 8'h02);
      row(1'b1);
      pulse();
      rd(ADDR_GUARD_LEFT, 8'h01);
      row(1'b1);
      row(1'b0);
      chk(rows - base, 8'h01);
      wr(ADDR_EXP_SYNC, 8'h06);
      base = rows;
      pulse();
      row(1'b1);
      pulse();
      rd(ADDR_GUARD_LEFT, 8'h02);
      row(1'b1);
      row(1'b1);
      row(1'b0);
      chk(rows - base, 8'h01);
      wr(ADDR_GUARD_CNT, 8'h00);
      base = rows;
      pulse();
      row(1'b0);
      chk(rows - base, 8'h01);
      finish_test();
   end
endmodule
`default_nettype wire
